/* File: core/cdiag_core.sv */
// CAN interrupt aggregation and diagnostic mode control
// Summary of operation
// - Six interrupt sources, each latching its own status bit.
// - Six sources merged onto four request outputs.
// - Status bit stays set until software writes zero.
// - Buffer transmit done drives tx line; reception drives rx line.
// - Error state, protocol error, arbitration loss share error line.
// - Buffer events count only when that buffer's enable is one.
// - Error state fires on warning level, passive or bus-off.
// - Protocol error fires on stuff, form, ack, bit or CRC error.
// - Wakeup fires on receive pin falling edge releasing sleep.
// - Receive-only: each valid acknowledged frame sets valid flag.
// - Receive-only: no transmission, transmit requests stay pending.
// - Receive-only: tx pin recessive, transmit error counter frozen.
// - Receive-only: no ack or overload driven, ack assumed internally.
// - Single-shot: no retry; retry bit one allows retry on arbitration loss.
// - Single-shot: request flag clears on success, error, or loss with retry bit zero.
// - Loss sets its status bit; error only clears the request flag, no status or error code.
// - Success sets tx status; line needs matching enable.
// - Retry bit matters only in single-shot mode.
// - Single-shot otherwise normal; not combined with block transmit.
// - Self-test: tx pin recessive, frames looped back internally.
// - Sleep entered from self-test still wakes on rx falling edge.
// - Bus wakeup sets status regardless of enable.
`timescale 1ns/100ps
`default_nettype none
module cdiag_core
  import cdiag_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [15:0] rdata,
  input  wire logic        bus_rx_pin,
  output logic             bus_tx_pin,
  input  wire logic        proto_tx_bit,
  input  wire logic        proto_ack_bit,
  output logic             proto_rx_bit,
  output logic             proto_ack_seen,
  input  wire logic        tx_ok,
  input  wire logic        tx_arb_lost,
  input  wire logic        tx_error,
  input  wire logic [3:0]  tx_buf,
  input  wire logic        rx_ok,
  input  wire logic        rx_stored,
  input  wire logic [3:0]  rx_buf,
  input  wire logic        proto_err,
  input  wire logic [2:0]  proto_err_code,
  input  wire logic        tec_inc,
  input  wire logic        tec_dec,
  input  wire logic        err_warning,
  input  wire logic        err_passive,
  input  wire logic        err_busoff,
  output logic             tx_enable,
  output logic             tx_retry,
  output logic             tx_request_line,
  output logic             rx_request_line,
  output logic             error_request_line,
  output logic             wakeup_request_line
);
  logic [5:0]  irq_status_reg;
  logic [5:0]  irq_enable_reg;
  logic [5:0]  irq_status_next;
  logic [5:0]  src_event;
  logic [15:0] buffer_irq_enable_reg;
  logic [15:0] transmit_request_flag_reg;
  logic [15:0] trq_next;
  logic [2:0]  last_error_code_reg;
  logic [7:0]  transmit_error_counter_reg;
  logic [2:0]  mode_reg;
  logic        arb_retry_bit_reg;
  logic        valid_reg;
  logic        sleep_reg;
  logic        sleep_next;
  logic        rx_meta_reg;
  logic        rx_sync_reg;
  logic        rx_prev_reg;
  logic        errst_prev_reg;
  logic [15:0] rdata_reg;
  logic        bus_tx_reg;

  function automatic logic [15:0] buf_onehot(input logic [3:0] idx);
    buf_onehot = 16'h0001 << idx;
  endfunction : buf_onehot

  wire cdiag_mode_t mode     = cdiag_mode_t'(mode_reg);
  wire logic is_rxonly       = (mode == CDIAG_RXONLY);
  wire logic is_single       = (mode == CDIAG_SINGLE);
  wire logic is_selftest     = (mode == CDIAG_SELFTEST);
  wire logic wr_status       = wr_stb && (addr == OFF_STATUS);
  wire logic wr_enable       = wr_stb && (addr == OFF_ENABLE);
  wire logic wr_ctrl         = wr_stb && (addr == OFF_CTRL);
  wire logic wr_bufie        = wr_stb && (addr == OFF_BUF_IE);
  wire logic wr_trq          = wr_stb && (addr == OFF_TRQ);
  wire logic errst_now       = err_warning || err_passive || err_busoff;
  wire logic rx_fall         = rx_prev_reg && !rx_sync_reg;
  wire logic wake_evt        = sleep_reg && rx_fall;
  wire logic tx_ev           = tx_ok && !is_rxonly;
  wire logic tx_buf_en       = buffer_irq_enable_reg[tx_buf];
  wire logic rx_buf_en       = buffer_irq_enable_reg[rx_buf];

  // Source events; buffer events gated by per-buffer enables
  assign src_event[SRC_TX]    = tx_ev && tx_buf_en;
  assign src_event[SRC_RX]    = rx_ok && rx_stored && rx_buf_en;
  assign src_event[SRC_ERRST] = errst_now && !errst_prev_reg;
  assign src_event[SRC_PROTO] = proto_err;
  assign src_event[SRC_ARB]   = tx_arb_lost && !is_rxonly;
  assign src_event[SRC_WAKE]  = wake_evt;

  // Set wins over a software clear
  assign irq_status_next = (wr_status ? (irq_status_reg & wdata[5:0])
                                      : irq_status_reg) | src_event;

  // Request lines gated by enable only
  assign tx_request_line     = irq_status_reg[SRC_TX] &&
                               irq_enable_reg[SRC_TX];
  assign rx_request_line     = irq_status_reg[SRC_RX] &&
                               irq_enable_reg[SRC_RX];
  assign error_request_line  = |(irq_status_reg[SRC_ARB:SRC_ERRST] &
                                 irq_enable_reg[SRC_ARB:SRC_ERRST]);
  assign wakeup_request_line = irq_status_reg[SRC_WAKE] &&
                               irq_enable_reg[SRC_WAKE];

  // Transmission gating and retry policy
  assign tx_enable = !is_rxonly && !sleep_reg &&
                     (|transmit_request_flag_reg);
  assign tx_retry  = is_single ? arb_retry_bit_reg : 1'b1;

  // Request flags: single-shot clears on error too, and on loss when retry bit is zero
  always_comb begin
    trq_next = wr_trq ? wdata : transmit_request_flag_reg;
    if (tx_ok && !is_rxonly) begin
      trq_next = trq_next & ~buf_onehot(tx_buf);
    end
    if (is_single && (tx_error || (tx_arb_lost && !arb_retry_bit_reg))) begin
      trq_next = trq_next & ~buf_onehot(tx_buf);
    end
  end

  // Internal loopback in self-test; pin held recessive in receive-only and self-test
  assign proto_rx_bit   = is_selftest ? proto_tx_bit : rx_sync_reg;
  assign proto_ack_seen = is_rxonly ? 1'b1 : proto_ack_bit;
  assign bus_tx_pin     = bus_tx_reg;

  assign sleep_next = wr_ctrl ? wdata[CTRL_SLEEP]
                              : (sleep_reg && !rx_fall);
  assign rdata = rdata_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= bus_rx_pin;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_tx_reg <= 1'b1;
    end else begin
      bus_tx_reg <= (is_rxonly || is_selftest) ? 1'b1 : proto_tx_bit;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_status_reg <= 6'h00;
      errst_prev_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      errst_prev_reg <= errst_now;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_enable_reg        <= 6'h00;
      buffer_irq_enable_reg <= DATA_RESET;
      mode_reg              <= 3'h0;
      arb_retry_bit_reg     <= 1'b0;
      sleep_reg             <= 1'b0;
    end else begin
      sleep_reg <= sleep_next;
      if (wr_enable) begin
        irq_enable_reg <= wdata[5:0];
      end
      if (wr_bufie) begin
        buffer_irq_enable_reg <= wdata;
      end
      if (wr_ctrl) begin
        mode_reg          <= wdata[CTRL_MODE_LSB +: 3];
        arb_retry_bit_reg <= wdata[CTRL_AL_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      transmit_request_flag_reg <= DATA_RESET;
    end else begin
      transmit_request_flag_reg <= trq_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      valid_reg <= 1'b0;
    end else if (is_rxonly && rx_ok) begin
      valid_reg <= 1'b1;
    end else if (wr_ctrl && !wdata[CTRL_VALID]) begin
      valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_error_code_reg <= 3'h0;
    end else if (proto_err) begin
      last_error_code_reg <= proto_err_code;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      transmit_error_counter_reg <= TEC_RESET;
    end else if (!is_rxonly) begin
      if (tec_inc && transmit_error_counter_reg != 8'hFF) begin
        transmit_error_counter_reg <= transmit_error_counter_reg + 8'h01;
      end else if (tec_dec && transmit_error_counter_reg != 8'h00) begin
        transmit_error_counter_reg <= transmit_error_counter_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_reg <= DATA_RESET;
    end else if (rd_stb) begin
      case (addr)
        OFF_STATUS: rdata_reg <= {10'h000, irq_status_reg};
        OFF_ENABLE: rdata_reg <= {10'h000, irq_enable_reg};
        OFF_CTRL:   rdata_reg <= {10'h000, sleep_reg, valid_reg,
                                  arb_retry_bit_reg, mode_reg};
        OFF_LEC:    rdata_reg <= {13'h0000, last_error_code_reg};
        OFF_BUF_IE: rdata_reg <= buffer_irq_enable_reg;
        OFF_TRQ:    rdata_reg <= transmit_request_flag_reg;
        OFF_TEC:    rdata_reg <= {8'h00, transmit_error_counter_reg};
        default:    rdata_reg <= DATA_RESET;
      endcase
    end else begin
      rdata_reg <= DATA_RESET;
    end
  end

  // Bus falling edge seen while asleep
  sequence s_bus_wake;
    sleep_reg && rx_prev_reg && !rx_sync_reg;
  endsequence

  // Wakeup latched and sleep released
  sequence s_wake_done;
    irq_status_reg[SRC_WAKE] && !sleep_reg;
  endsequence

  property p_status_sticky;
    @(posedge ref_clk) disable iff (rst)
      (irq_status_reg[SRC_WAKE] && !wr_status) |=> irq_status_reg[SRC_WAKE];
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("sticky lost");

  property p_set_wins;
    @(posedge ref_clk) disable iff (rst)
      (proto_err && wr_status) |=> irq_status_reg[SRC_PROTO];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("set lost");

  property p_wake;
    @(posedge ref_clk) disable iff (rst)
      s_bus_wake |=> s_wake_done;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wakeup not seen");

  property p_rxonly_pin;
    @(posedge ref_clk) disable iff (rst)
      is_rxonly |=> bus_tx_pin;
  endproperty
  a_rxonly_pin: assert property (p_rxonly_pin)
    else $error("tx not recessive");

  property p_rxonly_tec;
    @(posedge ref_clk) disable iff (rst)
      is_rxonly |=> $stable(transmit_error_counter_reg);
  endproperty
  a_rxonly_tec: assert property (p_rxonly_tec)
    else $error("tec moved");

  property p_valid;
    @(posedge ref_clk) disable iff (rst)
      (is_rxonly && rx_ok) |=> valid_reg;
  endproperty
  a_valid: assert property (p_valid)
    else $error("valid not set");

  property p_single_clear;
    @(posedge ref_clk) disable iff (rst)
      (is_single && tx_error && !wr_trq) |=>
        !transmit_request_flag_reg[$past(tx_buf)];
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("trq kept");

  property p_err_line;
    @(posedge ref_clk) disable iff (rst)
      (irq_status_reg[SRC_ARB] && irq_enable_reg[SRC_ARB]) |->
        error_request_line;
  endproperty
  a_err_line: assert property (p_err_line)
    else $error("error line low");

  property p_rxonly_hold;
    @(posedge ref_clk) disable iff (rst)
      is_rxonly |-> !tx_enable;
  endproperty
  a_rxonly_hold: assert property (p_rxonly_hold)
    else $error("tx enabled in monitor");

  property p_rxonly_ack;
    @(posedge ref_clk) disable iff (rst)
      is_rxonly |-> proto_ack_seen;
  endproperty
  a_rxonly_ack: assert property (p_rxonly_ack)
    else $error("ack not assumed");

  property p_selftest_pin;
    @(posedge ref_clk) disable iff (rst)
      is_selftest |=> bus_tx_pin;
  endproperty
  a_selftest_pin: assert property (p_selftest_pin)
    else $error("tx not recessive in self-test");

  property p_lec;
    @(posedge ref_clk) disable iff (rst)
      proto_err |=> (last_error_code_reg == $past(proto_err_code));
  endproperty
  a_lec: assert property (p_lec)
    else $error("error code not recorded");
endmodule : cdiag_core
`default_nettype wire

/* File: core/cdiag_pkg.sv */
// Package of constants for the CAN interrupt and diagnostic mode block
package cdiag_pkg;
  localparam int          NUM_SRC       = 6;
  localparam int          NUM_BUF       = 16;
  localparam logic [3:0]  ADDR_W        = 4'h4;
  localparam logic [3:0]  OFF_STATUS    = 4'h0;
  localparam logic [3:0]  OFF_ENABLE    = 4'h1;
  localparam logic [3:0]  OFF_CTRL      = 4'h2;
  localparam logic [3:0]  OFF_LEC       = 4'h3;
  localparam logic [3:0]  OFF_BUF_IE    = 4'h4;
  localparam logic [3:0]  OFF_TRQ       = 4'h5;
  localparam logic [3:0]  OFF_TEC       = 4'h6;
  localparam int          SRC_TX        = 0;
  localparam int          SRC_RX        = 1;
  localparam int          SRC_ERRST     = 2;
  localparam int          SRC_PROTO     = 3;
  localparam int          SRC_ARB       = 4;
  localparam int          SRC_WAKE      = 5;
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_AL_BIT   = 3;
  localparam int          CTRL_VALID    = 4;
  localparam int          CTRL_SLEEP    = 5;
  localparam logic [15:0] DATA_RESET    = 16'h0000;
  localparam logic [7:0]  TEC_RESET     = 8'h00;
  typedef enum logic [2:0] {
    CDIAG_NORMAL, CDIAG_ABT, CDIAG_RXONLY, CDIAG_SINGLE, CDIAG_SELFTEST
  } cdiag_mode_t;
endpackage : cdiag_pkg

/* File: tb/can_irq_and_diagnostic_modes_tb.sv */
// Self-checking bench for the CAN interrupt and diagnostic mode block
`timescale 1ns/100ps
`default_nettype none
module can_irq_and_diagnostic_modes_tb
  import cdiag_pkg::*;
;
  logic        ref_clk, rst, wr_stb, rd_stb, wake_req;
  logic [3:0]  addr, tx_buf, rx_buf;
  logic [15:0] wdata, rdata, v;
  logic        bus_rx_pin, bus_tx_pin, proto_tx_bit, proto_ack_bit;
  logic        proto_rx_bit, proto_ack_seen, tx_ok, tx_arb_lost, tx_error;
  logic        rx_ok, rx_stored, proto_err, tec_inc, tec_dec, err_warning;
  logic        err_passive, err_busoff, tx_enable, tx_retry;
  logic        tx_request_line, rx_request_line;
  logic        error_request_line, wakeup_request_line;
  logic [2:0]  proto_err_code;
  wire  [15:0] lines;
  int          bad_count, cmp_count, i;
  assign lines = {12'h000, tx_request_line, rx_request_line,
                  error_request_line, wakeup_request_line};
  cdiag_core uut (.ref_clk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .bus_rx_pin, .bus_tx_pin, .proto_tx_bit, .proto_ack_bit, .proto_rx_bit,
    .proto_ack_seen, .tx_ok, .tx_arb_lost, .tx_error, .tx_buf, .rx_ok,
    .rx_stored, .rx_buf, .proto_err, .proto_err_code, .tec_inc, .tec_dec,
    .err_warning, .err_passive, .err_busoff, .tx_enable, .tx_retry,
    .tx_request_line, .rx_request_line, .error_request_line,
    .wakeup_request_line);
  cdiag_bus_node node (.ref_clk, .rst, .wake_req, .bus_tx_pin, .bus_rx_pin);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask : rd
  task automatic rchk(input string n, input logic [3:0] a, logic [15:0] e);
    rd(a);
    chk(n, e, v);
  endtask : rchk
  task automatic ev(input int k, input logic [3:0] b);
    @(posedge ref_clk);
    tx_buf <= b;
    rx_buf <= b;
    case (k)
      0: tx_ok <= 1'b1;
      1: {rx_ok, rx_stored} <= 2'h3;
      2: tx_arb_lost <= 1'b1;
      3: tx_error <= 1'b1;
      4: proto_err <= 1'b1;
      default: tec_inc <= 1'b1;
    endcase
    @(posedge ref_clk);
    {tx_ok, rx_ok, rx_stored, tx_arb_lost, tx_error, proto_err,
     tec_inc} <= 7'h00;
    #1;
  endtask : ev
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    {wr_stb, rd_stb, wake_req, tx_ok, tx_arb_lost, tx_error} = 6'h00;
    {rx_ok, rx_stored, proto_err, tec_inc, tec_dec} = 5'h00;
    {err_warning, err_passive, err_busoff} = 3'h0;
    {proto_tx_bit, proto_ack_bit} = 2'h3;
    {addr, tx_buf, rx_buf, wdata} = 28'h0000000;
    proto_err_code = 3'h5;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rchk("status", OFF_STATUS, 16'h0000);
    chk("lines", 16'h0000, lines);
    $display("test reset done");
    wr(OFF_ENABLE, 16'h003F);
    wr(OFF_BUF_IE, 16'h0008);
    ev(0, 4'h3);
    rchk("status", OFF_STATUS, 16'h0001);
    chk("lines", 16'h0008, lines);
    wr(OFF_STATUS, 16'h0000);
    rchk("status", OFF_STATUS, 16'h0000);
    ev(0, 4'h2);
    rchk("status", OFF_STATUS, 16'h0000);
    ev(1, 4'h3);
    ev(4, 4'h0);
    ev(2, 4'h0);
    @(posedge ref_clk);
    err_warning <= 1'b1;
    rchk("status", OFF_STATUS, 16'h001E);
    chk("lines", 16'h0006, lines);
    rchk("lec", OFF_LEC, 16'h0005);
    wr(OFF_STATUS, 16'hFFFD);
    rchk("status", OFF_STATUS, 16'h001C);
    wr(OFF_ENABLE, 16'h0000);
    chk("lines", 16'h0000, lines);
    wr(OFF_ENABLE, 16'h0010);
    chk("lines", 16'h0002, lines);
    wr(OFF_STATUS, 16'h0000);
    wr(OFF_ENABLE, 16'h0000);
    @(posedge ref_clk);
    {addr, wdata, wr_stb, proto_err} <= {OFF_STATUS, 16'h0000, 2'h3};
    @(posedge ref_clk);
    {wr_stb, proto_err} <= 2'h0;
    rchk("status", OFF_STATUS, 16'h0008);
    wr(OFF_STATUS, 16'h0000);
    $display("test sources done");
    wr(OFF_CTRL, 16'h0024);
    @(posedge ref_clk);
    wake_req <= 1'b1;
    @(posedge ref_clk);
    wake_req <= 1'b0;
    v = 16'h0000;
    for (i = 0; i < 20 && v[SRC_WAKE] !== 1'b1; i++) begin
      rd(OFF_STATUS);
    end
    chk("poll", 16'h0020, v & 16'h0020);
    rchk("status", OFF_STATUS, 16'h0020);
    rchk("ctrl", OFF_CTRL, 16'h0004);
    wr(OFF_ENABLE, 16'h0020);
    chk("lines", 16'h0001, lines);
    $display("test wakeup done");
    @(posedge ref_clk);
    proto_tx_bit <= 1'b0;
    proto_ack_bit <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("loop", 16'h0000, {15'h0000, proto_rx_bit});
    chk("txpin", 16'h0001, {15'h0000, bus_tx_pin});
    wr(OFF_CTRL, 16'h0002);
    wr(OFF_TRQ, 16'h0001);
    chk("txen", 16'h0000, {15'h0000, tx_enable});
    chk("ack", 16'h0001, {15'h0000, proto_ack_seen});
    chk("txpin", 16'h0001, {15'h0000, bus_tx_pin});
    ev(5, 4'h0);
    rchk("tec", OFF_TEC, 16'h0000);
    ev(0, 4'h0);
    rchk("trq", OFF_TRQ, 16'h0001);
    ev(1, 4'h5);
    rchk("ctrl", OFF_CTRL, 16'h0012);
    $display("test rxonly done");
    wr(OFF_CTRL, 16'h0003);
    chk("retry", 16'h0000, {15'h0000, tx_retry});
    chk("txen", 16'h0001, {15'h0000, tx_enable});
    chk("ack", 16'h0000, {15'h0000, proto_ack_seen});
    ev(2, 4'h0);
    rchk("trq", OFF_TRQ, 16'h0000);
    wr(OFF_TRQ, 16'h0001);
    ev(3, 4'h0);
    rchk("trq", OFF_TRQ, 16'h0000);
    wr(OFF_CTRL, 16'h000B);
    chk("retry", 16'h0001, {15'h0000, tx_retry});
    wr(OFF_TRQ, 16'h0001);
    ev(2, 4'h0);
    rchk("trq", OFF_TRQ, 16'h0001);
    wr(OFF_CTRL, 16'h0000);
    chk("retry", 16'h0001, {15'h0000, tx_retry});
    ev(2, 4'h0);
    rchk("trq", OFF_TRQ, 16'h0001);
    $display("test single done");
    summarize();
  end
endmodule : can_irq_and_diagnostic_modes_tb
`default_nettype wire

/* File: tb/cdiag_bus_node.sv */
// Model of another node on the shared bus, wired-AND with the tx pin
`timescale 1ns/100ps
`default_nettype none
module cdiag_bus_node
  import cdiag_pkg::*;
#(
  parameter int DOM_LEN = 3
)(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic wake_req,
  input  wire logic bus_tx_pin,
  output logic      bus_rx_pin
);
  logic [7:0] dom_cnt_reg;
  logic [7:0] dom_cnt_next;
  assign dom_cnt_next = wake_req ? DOM_LEN[7:0] :
                        (dom_cnt_reg != 8'h00) ? dom_cnt_reg - 8'h01 : 8'h00;
  always_ff @(posedge ref_clk) begin
    dom_cnt_reg <= rst ? 8'h00 : dom_cnt_next;
  end
  // Bus pulled recessive when nobody drives dominant
  assign bus_rx_pin = bus_tx_pin & (dom_cnt_reg == 8'h00);
endmodule : cdiag_bus_node
`default_nettype wire
